// ==== rtl/mspi_slave.sv ====
// modbus rtu slave serving a shared process image, ahb-lite control
//
// Summary of operation
// - only the counted payload bytes are stored; later buffer bytes stay untouched.
// - the shared user data buffer holds at most 1024 bytes.
// - holding register reads come from the to-controller portion of the buffer.
// - input register reads come from the from-controller portion of the buffer.
// - fieldbus output image is updated only by serial write requests.
// - serially written values stay in the buffer and read back later.
// - multiple register writes touch only the addressed registers.
// - process byte index zero is the byte right after the length byte.
// - in trigger mode a control byte precedes the length byte.
// - slave id comes from two rotary switches, high and low digit.
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module mspi_slave
  import mspi_pkg::*;
#(
  parameter int BUF_BYTES     = mspi_pkg::BUF_BYTES_DEF,
  parameter int TO_PLC_BASE   = 0,
  parameter int FROM_PLC_BASE = 0
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // ahb-lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // rotary id switches
  input  wire logic [3:0]  slave_id_switch_high_in,
  input  wire logic [3:0]  slave_id_switch_low_in,
  // serial byte stream
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_frame_end_in,
  output logic      [7:0]  tx_byte_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  // fieldbus frame in
  input  wire logic [7:0]  fb_byte_in,
  input  wire logic        fb_valid_in,
  input  wire logic        fb_sof_in,
  // fieldbus output image
  input  wire logic [$clog2(mspi_pkg::BUF_BYTES_DEF)-1:0] fb_rd_addr_in,
  output logic      [7:0]  fb_rd_data_out,
  output logic             fb_out_update_out
);
  import mspi_pkg::*;
  localparam int AW = $clog2(BUF_BYTES_DEF);

  initial begin
    if (BUF_BYTES > BUF_BYTES_DEF || BUF_BYTES < 16) $error("BUF_BYTES out of range");
    if (TO_PLC_BASE >= BUF_BYTES || FROM_PLC_BASE >= BUF_BYTES) $error("bad portion base");
  end

  function automatic logic fits(input logic [17:0] base, input logic [17:0] cnt);
    return (cnt != 18'h0) && ((base + cnt) <= 18'(BUF_BYTES));
  endfunction : fits

  mspi_state_e state_ff;
  mspi_fb_e    fb_phase_ff;
  logic [7:0]  sw_s1_ff, sw_s2_ff, sw_s3_ff, slave_id_ff;
  logic        trig_mode_ff;
  logic [AW-1:0] fb_idx_ff;
  logic [7:0]  fb_remain_ff, fb_ctrl_ff;
  logic [7:0]  buf_mem [0:BUF_BYTES-1];
  logic [7:0]  req_mem [0:REQ_BYTES-1];
  logic [8:0]  rx_len_ff, req_len_ff;
  logic        rx_ovf_ff;
  logic [15:0] rx_crc_ff, rx_crc_step, tx_crc_ff, tx_crc_step;
  logic [8:0]  idx_ff, n_ff, src_ff, wr_k_ff, wr_cnt_ff;
  logic [17:0] rd_base_ff, wr_base_ff;
  logic        echo_ff, coil_ff;
  logic [7:0]  exc_ff, mem_q_ff, last_fc_ff;
  logic [2:0]  rem_ff;
  logic [15:0] good_cnt_ff, err_cnt_ff;
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [7:0]  nxt_tx_byte;
  logic [AW-1:0] eng_rd_addr, eng_addr;
  logic [7:0]  eng_wdata;
  logic        eng_we, fb_wr_en, frame_ok;
  logic [7:0]  req_fc;
  logic [15:0] req_start, req_qty;
  // decode results
  logic [17:0] d_base, d_cnt;
  logic [8:0]  d_n, d_src;
  logic [7:0]  d_exc;
  logic        d_write, d_echo, d_coil;

  assign req_fc    = req_mem[1];
  assign req_start = {req_mem[2], req_mem[3]};
  assign req_qty   = {req_mem[4], req_mem[5]};

  // id switches are pins: accept a value only once two stages agree
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sw_s1_ff    <= 8'h00;
      sw_s2_ff    <= 8'h00;
      sw_s3_ff    <= 8'h00;
      slave_id_ff <= 8'h00;
    end else begin
      sw_s1_ff <= {slave_id_switch_high_in, slave_id_switch_low_in};
      sw_s2_ff <= sw_s1_ff;
      sw_s3_ff <= sw_s2_ff;
      if (sw_s2_ff == sw_s3_ff) begin
        slave_id_ff <= sw_s3_ff;
      end
    end
  end

  // fieldbus frame: optional control byte, length byte, then payload
  assign fb_wr_en = fb_valid_in && !fb_sof_in && (fb_phase_ff == FB_DATA)
                    && (fb_remain_ff != 8'h00);
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fb_phase_ff  <= FB_CTRL;
      fb_idx_ff    <= '0;
      fb_remain_ff <= 8'h00;
      fb_ctrl_ff   <= 8'h00;
    end else if (fb_valid_in) begin
      if (fb_sof_in && trig_mode_ff) begin
        fb_ctrl_ff  <= fb_byte_in;
        fb_phase_ff <= FB_LEN;
      end else if (fb_sof_in || fb_phase_ff == FB_LEN) begin
        fb_remain_ff <= fb_byte_in;
        fb_idx_ff    <= '0;
        fb_phase_ff  <= FB_DATA;
      end else if (fb_wr_en) begin
        fb_remain_ff <= fb_remain_ff - 8'h01;
        fb_idx_ff    <= fb_idx_ff + AW'(1);
      end
    end
  end

  // shared buffer: fieldbus writes win, the engine retries its byte
  assign eng_addr = AW'(wr_base_ff + 18'(wr_k_ff));
  assign eng_we   = (state_ff == S_WWR) && !fb_wr_en;
  assign eng_rd_addr = (state_ff == S_WRD || state_ff == S_WWR) ? eng_addr
                     : AW'(rd_base_ff + 18'(idx_ff) - 18'(HDR_BYTES));
  always_comb begin
    if (coil_ff) begin
      eng_wdata = (req_mem[4] == COIL_ON) ? (mem_q_ff | (8'h01 << req_start[2:0]))
                                          : (mem_q_ff & ~(8'h01 << req_start[2:0]));
    end else begin
      eng_wdata = req_mem[8'(src_ff + wr_k_ff)];
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (fb_wr_en) begin
      buf_mem[fb_idx_ff] <= fb_byte_in;
    end else if (eng_we) begin
      buf_mem[eng_addr] <= eng_wdata;
    end
    mem_q_ff <= buf_mem[eng_rd_addr];
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fb_rd_data_out <= 8'h00;
    end else begin
      fb_rd_data_out <= buf_mem[fb_rd_addr_in];
    end
  end

  // request collection; bytes outside the idle state are dropped
  mspi_crc16_step u_rx_crc (.crc_in(rx_crc_ff), .data_in(rx_byte_in), .crc_out(rx_crc_step));
  assign frame_ok = !rx_ovf_ff && (rx_len_ff >= 9'(MIN_FRAME)) && (rx_crc_ff == 16'h0000)
                    && (req_mem[0] == slave_id_ff);
  always_ff @(posedge core_clk_in) begin
    if (state_ff == S_RX && rx_valid_in && rx_len_ff < 9'(REQ_BYTES)) begin
      req_mem[rx_len_ff[7:0]] <= rx_byte_in;
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_len_ff   <= 9'h000;
      rx_ovf_ff   <= 1'b0;
      rx_crc_ff   <= CRC_INIT;
      req_len_ff  <= 9'h000;
      good_cnt_ff <= 16'h0000;
      err_cnt_ff  <= 16'h0000;
    end else if (rx_frame_end_in) begin
      rx_len_ff <= 9'h000;
      rx_ovf_ff <= 1'b0;
      rx_crc_ff <= CRC_INIT;
      if (state_ff == S_RX && frame_ok) begin
        good_cnt_ff <= good_cnt_ff + 16'h0001;
        req_len_ff  <= rx_len_ff; // rx_len_ff is cleared here, decode needs the length later
      end else if (state_ff == S_RX && rx_len_ff >= 9'(MIN_FRAME) && rx_crc_ff != 16'h0000) begin
        err_cnt_ff <= err_cnt_ff + 16'h0001;
      end
    end else if (state_ff == S_RX && rx_valid_in) begin
      rx_crc_ff <= rx_crc_step;
      if (rx_len_ff < 9'(REQ_BYTES)) begin
        rx_len_ff <= rx_len_ff + 9'h001;
      end else begin
        rx_ovf_ff <= 1'b1;
      end
    end
  end

  // function decode of the held request
  always_comb begin
    d_base  = 18'h0;
    d_cnt   = 18'h0;
    d_write = 1'b0;
    d_echo  = 1'b0;
    d_coil  = 1'b0;
    d_src   = 9'(MULTI_SRC);
    d_exc   = EXC_NONE;
    case (req_fc)
      FC_RD_COILS, FC_RD_DISC: begin
        d_base = (18'(req_start) + 18'd7) >> 3;
        d_cnt  = (18'(req_qty) + 18'd7) >> 3;
      end
      FC_RD_HOLD: begin
        d_base = 18'(TO_PLC_BASE) + {1'b0, req_start, 1'b0};
        d_cnt  = {1'b0, req_qty, 1'b0};
      end
      FC_RD_INPUT: begin
        d_base = 18'(FROM_PLC_BASE) + {1'b0, req_start, 1'b0};
        d_cnt  = {1'b0, req_qty, 1'b0};
      end
      FC_WR_COIL: begin
        d_base  = 18'(req_start) >> 3;
        d_cnt   = 18'd1;
        d_write = 1'b1;
        d_echo  = 1'b1;
        d_coil  = 1'b1;
        d_src   = 9'(SINGLE_SRC);
        if (req_mem[4] != COIL_ON && req_mem[4] != COIL_OFF) d_exc = EXC_VALUE;
      end
      FC_WR_REG: begin
        d_base  = {1'b0, req_start, 1'b0};
        d_cnt   = 18'd2;
        d_write = 1'b1;
        d_echo  = 1'b1;
        d_src   = 9'(SINGLE_SRC);
      end
      FC_WR_COILS: begin
        d_base  = 18'(req_start) >> 3;
        d_cnt   = 18'(req_mem[6]);
        d_write = 1'b1;
        d_echo  = 1'b1;
      end
      FC_WR_REGS: begin
        d_base  = {1'b0, req_start, 1'b0};
        d_cnt   = 18'(req_mem[6]);
        d_write = 1'b1;
        d_echo  = 1'b1;
      end
      default: d_exc = EXC_FUNC;
    endcase
    if (d_exc == EXC_NONE && !fits(d_base, d_cnt)) d_exc = EXC_ADDR;
    if (d_exc == EXC_NONE && !d_write && d_cnt > 18'(MAX_RD_BYTES)) d_exc = EXC_VALUE;
    if (d_exc == EXC_NONE && d_write && (18'(d_src) + d_cnt + 18'd2) > 18'(req_len_ff)) begin
      d_exc = EXC_VALUE;
    end
    d_n = (d_exc != EXC_NONE) ? 9'(HDR_BYTES)
        : d_echo ? 9'(ECHO_BYTES) : 9'(HDR_BYTES) + d_cnt[8:0];
  end

  // answer byte: header, data or echo, then crc low and high
  mspi_crc16_step u_tx_crc (.crc_in(tx_crc_ff), .data_in(nxt_tx_byte), .crc_out(tx_crc_step));
  always_comb begin
    if (idx_ff == n_ff) nxt_tx_byte = tx_crc_ff[7:0];
    else if (idx_ff == n_ff + 9'h001) nxt_tx_byte = tx_crc_ff[15:8];
    else if (echo_ff && exc_ff == EXC_NONE) nxt_tx_byte = req_mem[idx_ff[7:0]];
    else if (idx_ff == 9'h000) nxt_tx_byte = slave_id_ff;
    else if (idx_ff == 9'h001) nxt_tx_byte = (exc_ff != EXC_NONE) ? (req_fc | EXC_FLAG) : req_fc;
    else if (idx_ff == 9'h002) nxt_tx_byte = (exc_ff != EXC_NONE) ? exc_ff : 8'(n_ff - 9'(HDR_BYTES));
    else if (idx_ff == n_ff - 9'h001 && rem_ff != 3'h0) nxt_tx_byte = mem_q_ff & ~(8'hff << rem_ff);
    else nxt_tx_byte = mem_q_ff;
  end

  // request engine
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff          <= S_RX;
      idx_ff            <= 9'h000;
      n_ff              <= 9'h000;
      src_ff            <= 9'h000;
      wr_k_ff           <= 9'h000;
      wr_cnt_ff         <= 9'h000;
      rd_base_ff        <= 18'h0;
      wr_base_ff        <= 18'h0;
      echo_ff           <= 1'b0;
      coil_ff           <= 1'b0;
      exc_ff            <= EXC_NONE;
      rem_ff            <= 3'h0;
      last_fc_ff        <= 8'h00;
      tx_crc_ff         <= CRC_INIT;
      tx_byte_out       <= 8'h00;
      tx_valid_out      <= 1'b0;
      fb_out_update_out <= 1'b0;
    end else begin
      fb_out_update_out <= 1'b0;
      case (state_ff)
        S_RX: begin
          if (rx_frame_end_in && frame_ok) state_ff <= S_EXEC;
        end
        S_EXEC: begin
          idx_ff     <= 9'h000;
          n_ff       <= d_n;
          src_ff     <= d_src;
          wr_k_ff    <= 9'h000;
          wr_cnt_ff  <= d_cnt[8:0];
          rd_base_ff <= d_base;
          wr_base_ff <= d_base;
          echo_ff    <= d_echo;
          coil_ff    <= d_coil;
          exc_ff     <= d_exc;
          rem_ff     <= (req_fc == FC_RD_COILS || req_fc == FC_RD_DISC) ? req_qty[2:0] : 3'h0;
          last_fc_ff <= req_fc;
          tx_crc_ff  <= CRC_INIT;
          state_ff   <= (d_write && d_exc == EXC_NONE) ? S_WRD : S_LOAD;
        end
        S_WRD: state_ff <= S_WWR;
        S_WWR: begin
          if (fb_wr_en) begin
            state_ff <= S_WRD; // re-read after the fieldbus byte lands
          end else if (wr_k_ff + 9'h001 == wr_cnt_ff) begin
            state_ff <= S_WDONE;
          end else begin
            wr_k_ff  <= wr_k_ff + 9'h001;
            state_ff <= S_WRD;
          end
        end
        S_WDONE: begin
          fb_out_update_out <= 1'b1;
          state_ff          <= S_LOAD;
        end
        S_LOAD: state_ff <= S_SEND;
        S_SEND: begin
          tx_byte_out  <= nxt_tx_byte;
          tx_valid_out <= 1'b1;
          if (idx_ff < n_ff) tx_crc_ff <= tx_crc_step;
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            idx_ff       <= idx_ff + 9'h001;
            state_ff     <= (idx_ff == n_ff + 9'h001) ? S_RX : S_LOAD;
          end
        end
        default: state_ff <= S_RX;
      endcase
    end
  end

  // ahb-lite: zero wait states, always okay, unmapped reads give zero
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 12'h000;
      trig_mode_ff  <= CTRL_TRIG_RST;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_ff    <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      wr_addr_ff    <= haddr_in[11:0];
      if (wr_pend_ff && wr_addr_ff == REG_CTRL) trig_mode_ff <= hwdata_in[CTRL_TRIG_BIT];
      if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
        case (haddr_in[11:0])
          REG_CTRL:   hrdata_out <= 32'(trig_mode_ff) << CTRL_TRIG_BIT;
          REG_STATUS: hrdata_out <= (32'(slave_id_ff) << STAT_ID_LSB)
                                  | (32'(last_fc_ff) << STAT_FC_LSB)
                                  | (32'(fb_ctrl_ff) << STAT_TRIG_LSB);
          REG_COUNT:  hrdata_out <= (32'(good_cnt_ff) << CNT_GOOD_LSB)
                                  | (32'(err_cnt_ff) << CNT_ERR_LSB);
          default:    hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_len_limit: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fb_wr_en |-> (fb_remain_ff != 8'h00) && (fb_phase_ff == FB_DATA)) else $error("payload past count");
  a_first_index: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (fb_valid_in && !fb_sof_in && fb_phase_ff == FB_LEN) |=> (fb_idx_ff == '0 && fb_phase_ff == FB_DATA))
    else $error("payload index not zero");
  a_ctrl_skip: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (fb_valid_in && fb_sof_in && trig_mode_ff) |=> (fb_phase_ff == FB_LEN && $stable(fb_remain_ff)))
    else $error("control byte not skipped");
  a_buf_range: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_ff == S_WWR) |-> (wr_base_ff + 18'(wr_k_ff) < 18'(BUF_BYTES))) else $error("write beyond buffer");
  a_update_cause: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fb_out_update_out |-> $past(state_ff) == S_WDONE ##1 !fb_out_update_out) else $error("stray update");
  a_hold_source: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_ff == S_LOAD && req_fc == FC_RD_HOLD && exc_ff == EXC_NONE && idx_ff >= 9'(HDR_BYTES)
     && idx_ff < n_ff) |-> eng_rd_addr == AW'(18'(TO_PLC_BASE) + {1'b0, req_start, 1'b0}
     + 18'(idx_ff) - 18'(HDR_BYTES))) else $error("holding read from wrong portion");
  a_input_source: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_ff == S_LOAD && req_fc == FC_RD_INPUT && exc_ff == EXC_NONE && idx_ff >= 9'(HDR_BYTES)
     && idx_ff < n_ff) |-> eng_rd_addr == AW'(18'(FROM_PLC_BASE) + {1'b0, req_start, 1'b0}
     + 18'(idx_ff) - 18'(HDR_BYTES))) else $error("input read from wrong portion");
  a_echo_bytes: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (tx_valid_out && echo_ff && exc_ff == EXC_NONE && idx_ff < n_ff)
    |-> tx_byte_out == req_mem[idx_ff[7:0]]) else $error("echo differs from request");
  a_coil_count: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (tx_valid_out && req_fc == FC_RD_COILS && exc_ff == EXC_NONE && idx_ff == 9'h002)
    |-> tx_byte_out == 8'((18'(req_qty) + 18'd7) >> 3)) else $error("bad coil byte count");
  a_id_settle: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (slave_id_ff != $past(slave_id_ff)) |-> $past(sw_s2_ff == sw_s3_ff)) else $error("id took unsettled value");
  a_value_kept: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    eng_we |=> buf_mem[$past(eng_addr)] == $past(eng_wdata)) else $error("written value lost");
  a_regs_only: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (eng_we && req_fc == FC_WR_REGS) |-> (18'(eng_addr) >= {1'b0, req_start, 1'b0})
    && (18'(eng_addr) < {1'b0, req_start, 1'b0} + 18'(req_mem[6]))) else $error("unaddressed register hit");
endmodule : mspi_slave

// ==== include/mspi_pkg.sv ====
// shared constants and types of the modbus slave process image block
package mspi_pkg;
  localparam int          BUF_BYTES_DEF = 1024;
  localparam int          REQ_BYTES     = 256;
  localparam int          MAX_RD_BYTES  = 250;
  localparam int          MIN_FRAME     = 4;
  localparam int          HDR_BYTES     = 3;
  localparam int          ECHO_BYTES    = 6;
  localparam int          SINGLE_SRC    = 4;
  localparam int          MULTI_SRC     = 7;
  localparam logic [7:0]  FC_RD_COILS   = 8'h01;
  localparam logic [7:0]  FC_RD_DISC    = 8'h02;
  localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT   = 8'h04;
  localparam logic [7:0]  FC_WR_COIL    = 8'h05;
  localparam logic [7:0]  FC_WR_REG     = 8'h06;
  localparam logic [7:0]  FC_WR_COILS   = 8'h0f;
  localparam logic [7:0]  FC_WR_REGS    = 8'h10;
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_NONE      = 8'h00;
  localparam logic [7:0]  EXC_FUNC      = 8'h01;
  localparam logic [7:0]  EXC_ADDR      = 8'h02;
  localparam logic [7:0]  EXC_VALUE     = 8'h03;
  localparam logic [7:0]  COIL_ON       = 8'hff;
  localparam logic [7:0]  COIL_OFF      = 8'h00;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_STATUS    = 12'h004;
  localparam logic [11:0] REG_COUNT     = 12'h008;
  localparam int          CTRL_TRIG_BIT = 0;
  localparam logic        CTRL_TRIG_RST = 1'b0;
  localparam int          STAT_ID_LSB   = 0;
  localparam int          STAT_FC_LSB   = 8;
  localparam int          STAT_TRIG_LSB = 16;
  localparam int          CNT_GOOD_LSB  = 0;
  localparam int          CNT_ERR_LSB   = 16;
  typedef enum logic [7:0] {
    S_RX    = 8'h01,
    S_EXEC  = 8'h02,
    S_LOAD  = 8'h04,
    S_SEND  = 8'h08,
    S_WAIT  = 8'h10,
    S_WRD   = 8'h20,
    S_WWR   = 8'h40,
    S_WDONE = 8'h80
  } mspi_state_e;
  typedef enum logic [2:0] {
    FB_CTRL = 3'b001,
    FB_LEN  = 3'b010,
    FB_DATA = 3'b100
  } mspi_fb_e;
endpackage : mspi_pkg

// ==== rtl/mspi_crc16_step.sv ====
// one byte step of the modbus rtu crc16
`timescale 1ns/100ps
module mspi_crc16_step
  import mspi_pkg::*;
(
  // running value and byte
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  // next value
  output logic      [15:0] crc_out
);
  always_comb begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (int b = 0; b < 8; b++) begin
      crc_out = crc_out[0] ? ((crc_out >> 1) ^ CRC_POLY) : (crc_out >> 1);
    end
  end
endmodule : mspi_crc16_step

// ==== verification/mspi_master_model.sv ====
// modbus rtu master model on the serial byte stream
`timescale 1ns/100ps
module mspi_master_model (
  // clock
  input  wire logic       clk_in,
  // request side
  output logic      [7:0] rx_byte_out,
  output logic            rx_valid_out,
  output logic            rx_frame_end_out,
  // answer side
  output logic            tx_ready_out,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in
);
  logic [7:0] rxq[$];
  logic [1:0] gap = 2'h0;
  logic       slow = 1'b0;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_frame_end_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // slow mode raises ready one cycle in four so held bytes get exercised
  always @(posedge clk_in) begin
    gap <= gap + 2'h1;
    tx_ready_out <= !slow || (gap == 2'h3);
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) rxq.push_back(tx_byte_in);
  end
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // request framing is kept by the master: crc appended low byte first
  task automatic transact(input logic [7:0] req[$], input int n);
    logic [15:0] c;
    c = crc16(req);
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    rxq.delete();
    foreach (req[i]) begin
      rx_byte_out <= req[i];
      rx_valid_out <= 1'b1;
      @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~req[req.size()-1];
    rx_frame_end_out <= 1'b1;
    @(posedge clk_in);
    rx_frame_end_out <= 1'b0;
    for (int t = 0; t < 400 && (n == 0 || rxq.size() < n); t++) @(posedge clk_in);
  endtask : transact
endmodule : mspi_master_model

// ==== verification/mspi_slave_bench.sv ====
// self-checking bench of the modbus slave process image
`timescale 1ns/100ps
module mspi_slave_bench;
  import mspi_pkg::*;
  logic        clk, rst_b, hsel, hwrite, hrdy, fb_valid, fb_sof, upd;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [3:0]  sw_hi, sw_lo;
  logic [7:0]  rx_byte, tx_byte, fb_byte, fb_data;
  logic        rx_valid, rx_end, tx_valid, tx_ready;
  logic [9:0]  fb_addr;
  logic [7:0]  q[$], e[$];
  int          bad_count = 0, tests_run = 0, cyc = 0, upd_cnt = 0;
  mspi_slave #(.FROM_PLC_BASE(8)) i_mspi_slave (.core_clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(), .slave_id_switch_high_in(sw_hi), .slave_id_switch_low_in(sw_lo),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_frame_end_in(rx_end),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .fb_byte_in(fb_byte), .fb_valid_in(fb_valid), .fb_sof_in(fb_sof),
    .fb_rd_addr_in(fb_addr), .fb_rd_data_out(fb_data), .fb_out_update_out(upd));
  mspi_master_model i_mspi_master_model (.clk_in(clk), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .rx_frame_end_out(rx_end), .tx_ready_out(tx_ready),
    .tx_byte_in(tx_byte), .tx_valid_in(tx_valid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // whole run needs about a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) upd_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic fb_frame(input logic [7:0] b[$]);
    foreach (b[i]) begin
      fb_byte <= b[i];
      fb_valid <= 1'b1;
      fb_sof <= (i == 0);
      @(posedge clk);
    end
    fb_valid <= 1'b0;
    fb_sof <= 1'b0;
    @(posedge clk);
  endtask : fb_frame
  task automatic fb_chk(input logic [9:0] a, input logic [7:0] exp);
    fb_addr <= a;
    repeat (2) @(posedge clk);
    chk(fb_data, exp);
  endtask : fb_chk
  function automatic void ramp(input logic [7:0] len, first, input int n);
    q = {len};
    for (int i = 0; i < n; i++) q.push_back(first + i[7:0]);
  endfunction : ramp
  task automatic xact();
    logic [15:0] c;
    c = i_mspi_master_model.crc16(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    i_mspi_master_model.transact(q, e.size());
    chk(i_mspi_master_model.rxq.size(), e.size());
    foreach (e[i]) chk(i_mspi_master_model.rxq[i], e[i]);
  endtask : xact
  initial begin
    {rst_b, hsel, hwrite, fb_valid, fb_sof, htrans} = '0;
    {haddr, hwdata, fb_byte, fb_addr} = '0;
    sw_hi = 4'h0;
    sw_lo = 4'h1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    ahb(1'b0, 32'h0, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, 32'h40, 32'hffff_ffff);
    ramp(8'h10, 8'ha0, 16);
    fb_frame(q);
    ramp(8'h08, 8'h01, 26);
    fb_frame(q);
    fb_chk(10'h0, 8'h01);
    fb_chk(10'h8, 8'ha8);
    chk(upd_cnt, 0);
    i_mspi_master_model.slow = 1'b1;
    q = {8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h38};
    e = {8'h01, 8'h01, 8'h07, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    xact();
    i_mspi_master_model.slow = 1'b0;
    for (int f = 3; f < 5; f++) begin
      ramp(8'h08, (f == 3) ? 8'h01 : 8'ha8, 8);
      e = {8'h01, f[7:0], q};
      q = {8'h01, f[7:0], 8'h00, 8'h00, 8'h00, 8'h04};
      xact();
    end
    q = {8'h01, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00};
    e = q;
    xact();
    chk(upd_cnt, 1);
    q = {8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08};
    e = {8'h01, 8'h01, 8'h01, 8'h03};
    xact();
    q = {8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h12, 8'h05};
    e = {8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01};
    xact();
    fb_chk(10'h7, 8'h08);
    fb_chk(10'h8, 8'h12);
    fb_chk(10'h9, 8'h05);
    fb_chk(10'ha, 8'haa);
    q = {8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    e = {};
    xact();
    ahb(1'b1, {20'h0, REG_CTRL}, 32'h1);
    fb_frame({8'h5c, 8'h02, 8'h55, 8'h66, 8'h77});
    fb_chk(10'h0, 8'h55);
    fb_chk(10'h2, 8'h03);
    q = {8'h01, 8'h0f, 8'h00, 8'h08, 8'h00, 8'h08, 8'h01, 8'h5a};
    e = {8'h01, 8'h0f, 8'h00, 8'h08, 8'h00, 8'h08};
    xact();
    fb_chk(10'h1, 8'h5a);
    q = {8'h01, 8'h06, 8'h00, 8'h07, 8'h12, 8'h34};
    e = q;
    xact();
    fb_chk(10'he, 8'h12);
    fb_chk(10'hf, 8'h34);
    chk(upd_cnt, 4);
    ahb(1'b0, {20'h0, REG_COUNT}, 32'h0);
    chk(r, 32'h0000_0008);
    ahb(1'b0, {20'h0, REG_STATUS}, 32'h0);
    chk(r[7:0], 8'h01);
    chk(r[23:16], 8'h5c);
    print_verdict();
  end
endmodule : mspi_slave_bench
